//--- hw/fm_pkg.sv
// Package with register map, field layout and constants of the frequency meter.
package fm_pkg;

  localparam logic [9:0]  ADDR_CONTROL     = 10'h000;
  localparam logic [9:0]  ADDR_CONFIG      = 10'h004;
  localparam logic [9:0]  ADDR_STATE       = 10'h008;
  localparam logic [9:0]  ADDR_COUNT       = 10'h00c;
  localparam logic [9:0]  ADDR_IRQ_EN_SET  = 10'h010;
  localparam logic [9:0]  ADDR_IRQ_EN_CLR  = 10'h014;
  localparam logic [9:0]  ADDR_IRQ_MASK    = 10'h018;
  localparam logic [9:0]  ADDR_IRQ_PEND    = 10'h01c;
  localparam logic [9:0]  ADDR_IRQ_PEND_CLR = 10'h020;
  localparam logic [9:0]  ADDR_REVISION    = 10'h3fc;

  localparam int          START_BIT        = 0;
  localparam int          BUSY_BIT         = 0;
  localparam int          SWITCHING_BIT    = 1;
  localparam int          IRQ_DONE_BIT     = 0;
  localparam int          IRQ_REF_RDY_BIT  = 1;

  localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
  localparam logic [23:0] COUNT_RESET      = 24'h00_0000;
  localparam logic [1:0]  IRQ_RESET        = 2'h0;
  // Arbitrary neutral revision value.
  localparam logic [31:0] REVISION_VALUE   = 32'h0000_0100;

  localparam int          COUNT_WIDTH      = 24;
  localparam int          MSR_SOURCES      = 8;
  localparam int          REF_SOURCES      = 8;
  // Edges of the active reference source needed to finish a switch.
  localparam logic [1:0]  SWITCH_EDGES     = 2'h2;

  typedef struct packed {
    logic       ref_clock_enable;
    logic [9:0] rsv_hi;
    logic [4:0] measured_source_select;
    logic [7:0] reference_cycle_count;
    logic [4:0] rsv_lo;
    logic [2:0] reference_source_select;
  } fm_config_s;

endpackage

//--- hw/fm_frequency_meter.sv
// Frequency meter: counts measured-clock edges over a window of reference-clock edges.
// Contract
// - Writing one to control bit 0 starts a measurement; zero does nothing.
// - Config bits 15:8 give window length in reference clock periods.
// - Config bits 20:16 choose the measured clock source.
// - Config bits 2:0 choose the reference clock source.
// - Config bit 31 enables the reference clock when one.
// - Switching status bit 1 sets on any config write, clears when reference ready.
// - Busy bit 0 is one during a measurement, zero when done.
// - Result register holds measured cycle count on completion.
// - Result is a 24-bit count; upper bits read zero.
// - Stopped reference leaves busy set forever, no completion interrupt.
// - Reference cannot switch while the active reference source is stopped.
// - Done and reference-ready requests, masked, ORed into one interrupt output.
// - Pending bits set on falling busy and falling switching status.
// - Enable-set writes of one set mask bits; enable-clear writes clear them.
// - Interrupt holds until pending cleared; pending-clear ones clear bits.
// - Meter keeps running while the processor is halted for debug.
// - Measured source codes 0 to 7 map to the eight clock inputs in order.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module fm_frequency_meter (
  input  wire logic        clock,          // Bus interface clock, 25 MHz.
  input  wire logic        nrst,           // Asynchronous reset, active low.
  input  wire logic        clk_en,         // Freezes all state while low.
  input  wire logic [9:0]  addr,           // Register byte address.
  input  wire logic [31:0] wdata,          // Write data.
  input  wire logic        wr,             // Write strobe.
  input  wire logic        rd,             // Read strobe.
  output logic      [31:0] rdata,          // Read data, valid the cycle after rd.
  input  wire logic [7:0]  measured_clock, // Candidate measured clocks.
  input  wire logic [7:0]  ref_sources,    // Candidate reference clocks.
  output logic             irq             // Interrupt request, active high.
);

  // Idle, waiting for the first usable reference edge, then counting the window.
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARM,
    MEAS_COUNT
  } fm_meas_e;

  // Inputs are sampled, so each candidate clock must stay below half of 25 MHz.
  logic [7:0]  msr_sync1_reg;
  logic [7:0]  msr_sync2_reg;
  logic [7:0]  ref_sync1_reg;
  logic [7:0]  ref_sync2_reg;
  logic        msr_prev_reg;
  logic        ref_prev_reg;
  fm_pkg::fm_config_s config_reg;
  logic [2:0]  ref_active_reg;
  logic        switching_reg;
  logic [1:0]  switch_edges_reg;
  logic        busy_reg;
  logic [7:0]  ref_count_reg;
  logic [23:0] msr_count_reg;
  logic [23:0] result_reg;
  logic        busy_prev_reg;
  logic        switching_prev_reg;
  logic [1:0]  mask_reg;
  logic [1:0]  pending_reg;
  logic [1:0]  pending_next;
  logic        msr_level;
  logic        ref_level;
  logic        msr_edge;
  logic        ref_edge;
  logic        start_write;
  logic        config_write;
  logic        window_end;
  logic        ref_tick;
  logic        done_event;
  logic        ready_event;
  logic        hit_control;
  logic        hit_config;
  logic        hit_state;
  logic        hit_count;
  logic        hit_en_set;
  logic        hit_en_clr;
  logic        hit_mask;
  logic        hit_pend;
  logic        hit_pend_clr;
  logic        hit_revision;
  logic [31:0] read_next;
  fm_meas_e    meas_state_reg;
  fm_meas_e    meas_state_next;

  function automatic logic rising(input logic prev, input logic cur);
    rising = cur & ~prev;
  endfunction

  // Full ten-bit compare, so no alias of a register answers.
  function automatic logic reg_hit(input logic [9:0] a, input logic [9:0] offset);
    reg_hit = (a == offset);
  endfunction

  function automatic logic pick_bit(input logic [7:0] bits, input logic [2:0] sel);
    pick_bit = bits[sel];
  endfunction

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      msr_sync1_reg <= 8'h00;
      msr_sync2_reg <= 8'h00;
    end else if (clk_en) begin
      msr_sync1_reg <= measured_clock;
      msr_sync2_reg <= msr_sync1_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_sync1_reg <= 8'h00;
      ref_sync2_reg <= 8'h00;
    end else if (clk_en) begin
      ref_sync1_reg <= ref_sources;
      ref_sync2_reg <= ref_sync1_reg;
    end
  end

  always_comb begin
    if (config_reg.measured_source_select < 5'(fm_pkg::MSR_SOURCES)) begin
      msr_level = pick_bit(msr_sync2_reg, config_reg.measured_source_select[2:0]);
    end else begin
      msr_level = 1'b0;
    end
  end

  assign ref_level = pick_bit(ref_sync2_reg, ref_active_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      msr_prev_reg <= 1'b0;
    end else if (clk_en) begin
      msr_prev_reg <= msr_level;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_prev_reg <= 1'b0;
    end else if (clk_en) begin
      ref_prev_reg <= ref_level;
    end
  end

  assign msr_edge     = rising(msr_prev_reg, msr_level);
  assign ref_edge     = rising(ref_prev_reg, ref_level);
  assign hit_control  = reg_hit(addr, fm_pkg::ADDR_CONTROL);
  assign hit_config   = reg_hit(addr, fm_pkg::ADDR_CONFIG);
  assign hit_state    = reg_hit(addr, fm_pkg::ADDR_STATE);
  assign hit_count    = reg_hit(addr, fm_pkg::ADDR_COUNT);
  assign hit_en_set   = reg_hit(addr, fm_pkg::ADDR_IRQ_EN_SET);
  assign hit_en_clr   = reg_hit(addr, fm_pkg::ADDR_IRQ_EN_CLR);
  assign hit_mask     = reg_hit(addr, fm_pkg::ADDR_IRQ_MASK);
  assign hit_pend     = reg_hit(addr, fm_pkg::ADDR_IRQ_PEND);
  assign hit_pend_clr = reg_hit(addr, fm_pkg::ADDR_IRQ_PEND_CLR);
  assign hit_revision = reg_hit(addr, fm_pkg::ADDR_REVISION);
  assign start_write  = wr && hit_control && wdata[fm_pkg::START_BIT];
  assign config_write = wr && hit_config;
  // reference periods count only while enabled
  assign ref_tick     = ref_edge && config_reg.ref_clock_enable && !switching_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      config_reg <= fm_pkg::CONFIG_RESET;
    end else if (clk_en && config_write) begin
      config_reg <= fm_pkg::fm_config_s'(wdata);
    end
  end

  // Reference switching: finishes only after edges of the active source, so a
  // stopped source keeps the switch pending and the select cannot move.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      switching_reg    <= 1'b0;
      switch_edges_reg <= 2'h0;
      ref_active_reg   <= 3'h0;
    end else if (clk_en) begin
      if (config_write) begin
        switching_reg    <= 1'b1;
        switch_edges_reg <= 2'h0;
      end else if (switching_reg && ref_edge) begin
        if (switch_edges_reg + 2'h1 >= fm_pkg::SWITCH_EDGES) begin
          switching_reg  <= 1'b0;
          ref_active_reg <= config_reg.reference_source_select;
        end else begin
          switch_edges_reg <= switch_edges_reg + 2'h1;
        end
      end
    end
  end

  // window length in reference periods; a zero window ends on the first edge.
  assign window_end = (meas_state_reg == MEAS_COUNT) && ref_tick
                      && (ref_count_reg + 8'h01 >= config_reg.reference_cycle_count);

  // A start lands part way through a reference period. Opening the window on the
  // next usable reference edge makes it span whole periods, at the cost of up to
  // one extra reference period of latency.
  always_comb begin
    meas_state_next = meas_state_reg;
    case (meas_state_reg)
      MEAS_IDLE: begin
        meas_state_next = MEAS_IDLE;
      end
      MEAS_ARM: begin
        if (ref_tick) begin
          meas_state_next = MEAS_COUNT;
        end
      end
      MEAS_COUNT: begin
        if (window_end) begin
          meas_state_next = MEAS_IDLE;
        end
      end
      default: begin
        meas_state_next = MEAS_IDLE;
      end
    endcase
    if (start_write) begin
      meas_state_next = MEAS_ARM;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meas_state_reg <= MEAS_IDLE;
    end else if (clk_en) begin
      meas_state_reg <= meas_state_next;
    end
  end

  // no debug halt input, measurement freezes only while clk_en is low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg      <= 1'b0;
      ref_count_reg <= 8'h00;
      msr_count_reg <= fm_pkg::COUNT_RESET;
      result_reg    <= fm_pkg::COUNT_RESET;
    end else if (clk_en) begin
      if (start_write) begin
        busy_reg      <= 1'b1;
        ref_count_reg <= 8'h00;
        msr_count_reg <= fm_pkg::COUNT_RESET;
      end else if (meas_state_reg == MEAS_COUNT) begin
        if (ref_tick) begin
          ref_count_reg <= ref_count_reg + 8'h01;
        end
        if (msr_edge) begin
          msr_count_reg <= msr_count_reg + 24'h00_0001;
        end
        // no reference edges keeps busy set
        if (window_end) begin
          busy_reg   <= 1'b0;
          result_reg <= msr_count_reg + {23'h00_0000, msr_edge};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_prev_reg <= 1'b0;
    end else if (clk_en) begin
      busy_prev_reg <= busy_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      switching_prev_reg <= 1'b0;
    end else if (clk_en) begin
      switching_prev_reg <= switching_reg;
    end
  end

  assign done_event  = busy_prev_reg && !busy_reg;
  assign ready_event = switching_prev_reg && !switching_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= fm_pkg::IRQ_RESET;
    end else if (clk_en && wr) begin
      if (hit_en_set) begin
        mask_reg <= mask_reg | wdata[1:0];
      end else if (hit_en_clr) begin
        mask_reg <= mask_reg & ~wdata[1:0];
      end
    end
  end

  always_comb begin
    pending_next = pending_reg;
    if (wr && hit_pend_clr) begin
      pending_next = pending_next & ~wdata[1:0];
    end
    // set on falling status, set beats clear
    if (done_event) begin
      pending_next[fm_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (ready_event) begin
      pending_next[fm_pkg::IRQ_REF_RDY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pending_reg <= fm_pkg::IRQ_RESET;
    end else if (clk_en) begin
      pending_reg <= pending_next;
    end
  end

  assign irq = |(pending_reg & mask_reg);

  // Read mux; unmapped and write-only offsets read as zero.
  always_comb begin
    read_next = 32'h0000_0000;
    if (hit_config) begin
      read_next = config_reg;
    end else if (hit_state) begin
      read_next = {30'h0000_0000, switching_reg, busy_reg};
    end else if (hit_count) begin
      read_next = {8'h00, result_reg};
    end else if (hit_mask) begin
      read_next = {30'h0000_0000, mask_reg};
    end else if (hit_pend) begin
      read_next = {30'h0000_0000, pending_reg};
    end else if (hit_revision) begin
      read_next = fm_pkg::REVISION_VALUE;
    end
  end

  // Data stands for one cycle only, so a stale word is never taken for a reply.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rd) begin
        rdata <= read_next;
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/fm_checker.sv
// Port assertions for the frequency meter.
`timescale 1ns/100ps
`default_nettype none
module fm_checker (
  input wire logic        clock,  // Bus clock.
  input wire logic        nrst,   // Reset.
  input wire logic        clk_en, // Enable.
  input wire logic [9:0]  addr,   // Address.
  input wire logic [31:0] wdata,  // Write data.
  input wire logic        wr,     // Write.
  input wire logic        rd,     // Read.
  input wire logic [31:0] rdata,  // Read data.
  input wire logic        irq     // Interrupt.
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence rd_at(logic [9:0] a);
    rd && clk_en && addr == a;
  endsequence
  AST_COUNT_HI: assert property (rd_at(fm_pkg::ADDR_COUNT) |=> rdata[31:24] == 8'h0)
    else $error("count upper bits set");
  AST_STATE_HI: assert property (rd_at(fm_pkg::ADDR_STATE) |=> rdata[31:2] == 30'h0)
    else $error("state upper bits set");
  AST_SWITCH_SET: assert property ((wr && clk_en && addr == fm_pkg::ADDR_CONFIG)
    ##1 rd_at(fm_pkg::ADDR_STATE) |=> rdata[1]) else $error("switching not set");
  AST_START_BUSY: assert property ((wr && clk_en && addr == 10'h0 && wdata[0])
    ##1 rd_at(fm_pkg::ADDR_STATE) |=> rdata[0]) else $error("busy not set");
  AST_CFG_RB: assert property ((wr && clk_en && addr == fm_pkg::ADDR_CONFIG) ##1 !wr[*2]
    ##1 rd_at(fm_pkg::ADDR_CONFIG) |=> rdata == $past(wdata, 4)) else $error("config lost");
  AST_IRQ_OFF: assert property ((wr && addr == fm_pkg::ADDR_IRQ_EN_CLR && wdata[1:0] == 2'h3
    && clk_en) |=> !irq) else $error("irq after mask clear");
  AST_IRQ_ON: assert property (rd_at(fm_pkg::ADDR_IRQ_PEND) ##1 (rdata[0] && !wr)
    ##1 rd_at(fm_pkg::ADDR_IRQ_MASK) ##1 rdata[0] |-> irq) else $error("irq missing");
  AST_IRQ_MASKED: assert property (rd_at(fm_pkg::ADDR_IRQ_MASK) ##1 rdata[1:0] == 2'h0
    |-> !irq) else $error("irq while masked");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (wr && addr == fm_pkg::ADDR_CONTROL && wdata[0]);
endmodule
bind fm_frequency_meter fm_checker chk_u (.clock, .nrst, .clk_en, .addr, .wdata, .wr, .rd,
  .rdata, .irq);
`default_nettype wire

//--- bench/fm_clock_model.sv
// Clock sources that feed the meter's selectors.
`timescale 1ns/100ps
`default_nettype none
module fm_clock_model (
  input  wire logic [7:0] ref_stop,       // Stops a reference source.
  output var  logic [7:0] measured_clock, // Measured candidates.
  output var  logic [7:0] ref_sources     // Reference candidates.
);
  for (genvar i = 0; i < 8; i++) begin : g_src
    initial begin
      measured_clock[i] = 1'b0;
      forever #(80 + 40 * i) measured_clock[i] = ~measured_clock[i];
    end
    // A stopped source parks low like a gated oscillator, never mid-pulse.
    initial begin
      ref_sources[i] = 1'b0;
      forever #(400 + 200 * i) ref_sources[i] = ~ref_sources[i] & ~ref_stop[i];
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the frequency meter.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  localparam logic [7:0] WIN = 8'h04;
  logic        clock, nrst, clk_en, wr, rd, irq;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  msr, refs, ref_stop;
  logic [2:0]  rsel;
  int          error_cnt, num_checks;
  fm_clock_model src_u (.ref_stop(ref_stop), .measured_clock(msr), .ref_sources(refs));
  fm_frequency_meter dut_u (.clock(clock), .nrst(nrst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .measured_clock(msr),
    .ref_sources(refs), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] cfg(logic en, logic [4:0] ms, logic [2:0] rs);
    fm_pkg::fm_config_s c;
    c = '0;
    c.ref_clock_enable = en;
    c.measured_source_select = ms;
    c.reference_cycle_count = WIN;
    c.reference_source_select = rs;
    return c;
  endfunction
  // With rs set the state register is read in the very next cycle.
  task automatic wreg(logic [9:0] a, logic [31:0] d, bit rs = 1'b0);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rd <= rs;
    addr <= rs ? fm_pkg::ADDR_STATE : a;
    @(posedge clock);
    rd <= 1'b0;
    #1 q = rdata;
    @(posedge clock);
  endtask
  task automatic rreg(logic [9:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 q = rdata;
    @(posedge clock);
  endtask
  task automatic wait_clear(int b);
    int n;
    n = 0;
    do begin
      rreg(fm_pkg::ADDR_STATE);
      n++;
    end while (q[b] !== 1'b0 && n < 200);
    `CHK("state bit", 1'b0, q[b])
  endtask
  task automatic measure(logic [4:0] ms);
    int e;
    e = int'(WIN) * (800 + 400 * rsel) / (160 + 80 * ms);
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b1, ms, rsel), 1'b1);
    `CHK("switching", 1'b1, q[1])
    wait_clear(1);
    wreg(fm_pkg::ADDR_CONTROL, 32'h1, 1'b1);
    `CHK("busy", 1'b1, q[0])
    wait_clear(0);
    rreg(fm_pkg::ADDR_COUNT);
    `CHK("count", 1'b1, q + 1 >= e && q <= e + 1)
  endtask
  task automatic t_reset();
    logic [9:0] ra[7] = '{fm_pkg::ADDR_CONFIG, fm_pkg::ADDR_STATE, fm_pkg::ADDR_COUNT,
      fm_pkg::ADDR_IRQ_MASK, fm_pkg::ADDR_IRQ_PEND, fm_pkg::ADDR_REVISION, 10'h100};
    foreach (ra[i]) begin
      rreg(ra[i]);
      `CHK("reset read", (i == 5) ? fm_pkg::REVISION_VALUE : 32'h0, q)
    end
  endtask
  task automatic t_enable();
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b0, 5'h0, 3'h0));
    rreg(fm_pkg::ADDR_CONFIG);
    `CHK("config", cfg(1'b0, 5'h0, 3'h0), q)
    wait_clear(1);
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b1, 5'h0, 3'h0), 1'b1);
    `CHK("switching", 1'b1, q[1])
    wait_clear(1);
    rreg(fm_pkg::ADDR_IRQ_PEND);
    `CHK("ready pend", 2'h2, q[1:0])
  endtask
  task automatic t_irq();
    wreg(fm_pkg::ADDR_IRQ_EN_SET, 32'h1);
    wreg(fm_pkg::ADDR_CONTROL, 32'h0, 1'b1);
    `CHK("zero start", 1'b0, q[0])
    for (int ms = 0; ms < 8; ms++) measure(ms[4:0]);
    rreg(fm_pkg::ADDR_IRQ_PEND);
    `CHK("done pend", 2'h3, q[1:0])
    rreg(fm_pkg::ADDR_IRQ_MASK);
    `CHK("mask", 32'h1, q)
    `CHK("irq", 1'b1, irq)
    wreg(fm_pkg::ADDR_IRQ_PEND_CLR, 32'h3);
    rreg(fm_pkg::ADDR_IRQ_PEND);
    `CHK("pend clr", 32'h0, q)
    `CHK("irq clr", 1'b0, irq)
    wreg(fm_pkg::ADDR_IRQ_EN_CLR, 32'h3);
    rreg(fm_pkg::ADDR_IRQ_MASK);
    `CHK("mask clr", 32'h0, q)
  endtask
  task automatic t_stop();
    ref_stop <= 8'h01;
    wreg(fm_pkg::ADDR_CONTROL, 32'h1);
    repeat (100) @(posedge clock);
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b0, 5'h0, 3'h0), 1'b1);
    `CHK("stuck busy", 1'b1, q[0])
    repeat (100) @(posedge clock);
    rreg(fm_pkg::ADDR_STATE);
    `CHK("switch held", 2'h3, q[1:0])
    ref_stop <= 8'h00;
    wait_clear(1);
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b0, 5'h0, 3'h1));
    wait_clear(1);
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b1, 5'h0, 3'h1));
    wait_clear(1);
    wait_clear(0);
    rsel = 3'h1;
    measure(5'h0);
  endtask
  // The meter is quiesced first; a write while the clock is gated must not land.
  task automatic t_gate();
    wreg(fm_pkg::ADDR_CONFIG, cfg(1'b0, 5'h0, 3'h1));
    wait_clear(1);
    clk_en <= 1'b0;
    wreg(fm_pkg::ADDR_IRQ_EN_SET, 32'h3);
    clk_en <= 1'b1;
    rreg(fm_pkg::ADDR_IRQ_MASK);
    `CHK("frozen mask", 32'h0, q)
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {nrst, wr, rd, addr, wdata, ref_stop, rsel} = '0;
    clk_en = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_enable();
    t_irq();
    t_stop();
    t_gate();
    finish_test();
  end
  // The full run needs about 2000 bus cycles; this allows twenty-five times that.
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
